// >>> logic/asf_defs.svh
// constants for the accumulator store formatter: offsets, fields, opcodes, limits
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// ====================================================================
// register map
`define ASF_OFF_CTRL 8'h00
`define ASF_OFF_INSTR 8'h04
`define ASF_OFF_STATUS 8'h08
`define ASF_OFF_RESULT 8'h0C
`define ASF_OFF_SHIFT_BASE 8'h10
`define ASF_SHIFT_MASK 8'hF0
`define ASF_SHIFT_IDX 3:2
`define ASF_OFF_ACC_BASE 8'h20
`define ASF_ACC_MASK 8'hE0
`define ASF_ACC_IDX 4:3
`define ASF_ACC_HALF 2
`define ASF_ADDR_ALIGN 1:0

// ====================================================================
// control bits
`define ASF_CTRL_LCM 0
`define ASF_CTRL_SXM 1
`define ASF_CTRL_SST 2
`define ASF_CTRL_RDM 3
`define ASF_CTRL_W 4

// ====================================================================
// instruction word fields (first opcode byte in the top byte)
`define ASF_F_OPC 31:24
`define ASF_F_OPC6 31:26
`define ASF_F_ACC2 25:24
`define ASF_F_ADDR 23:16
`define ASF_F_ACC3 15:14
`define ASF_F_TXSEL 13:12
`define ASF_F_SUB 11:10
`define ASF_F_RND 8
`define ASF_F_IMM 13:8
`define ASF_OP_HI_PLAIN 6'h2F
`define ASF_OP_HI_RND 8'hE8
`define ASF_OP_TX 8'hE7
`define ASF_OP_LO_IMM 8'hE9
`define ASF_OP_HI_IMM 8'hEA
`define ASF_OP_LONG 8'hEB
`define ASF_OP_LONG_USAT 8'hEC
`define ASF_OP_LONG_HALF 8'hED
`define ASF_OP_DUAL 8'hEE
`define ASF_SUB_TX_LO 2'h0
`define ASF_SUB_TX_HI 2'h2

// ====================================================================
// shift and saturation limits
`define ASF_SHIFT_MAX16 16'h001F
`define ASF_SHIFT_MIN16 16'hFFE0
`define ASF_SHIFT_MAX6 6'h1F
`define ASF_SHIFT_MIN6 6'h20
`define ASF_LEG_WRAP_LO 6'h20
`define ASF_LEG_WRAP_HI 6'h2F
`define ASF_LEG_WRAP_ADD 6'h10
`define ASF_HALF_LSB 16'h8000
`define ASF_ROUND_INC 40'h0000008000
`define ASF_SAT_POS_S 40'h007FFFFFFF
`define ASF_SAT_NEG_S 40'hFF80000000
`define ASF_SAT_POS_U 40'h00FFFFFFFF
`define ASF_SAT_ZERO 40'h0000000000

`endif

// >>> logic/asf_pkg.sv
// types shared by the accumulator store formatter and its bench
package asf_pkg;

	// ====================================================================
	// memory write kinds
	typedef enum logic [1:0] {
		ASF_KIND_SINGLE = 2'h0,
		ASF_KIND_LONG = 2'h1,
		ASF_KIND_DUAL = 2'h2
	} asf_kind_t;

	// ====================================================================
	// decoded store forms, one-hot
	typedef enum logic [10:0] {
		ASF_FORM_NONE = 11'h001,
		ASF_FORM_HI_PLAIN = 11'h002,
		ASF_FORM_HI_RND = 11'h004,
		ASF_FORM_TX_LO = 11'h008,
		ASF_FORM_TX_HI = 11'h010,
		ASF_FORM_IMM_LO = 11'h020,
		ASF_FORM_IMM_HI = 11'h040,
		ASF_FORM_LONG = 11'h080,
		ASF_FORM_LONG_USAT = 11'h100,
		ASF_FORM_LONG_HALF = 11'h200,
		ASF_FORM_DUAL = 11'h400
	} asf_form_t;

	// ====================================================================
	// data-memory write port
	typedef struct packed {
		logic valid;
		asf_kind_t kind;
		logic [7:0] addr;
		logic [15:0] data_hi;
		logic [15:0] data_lo;
	} asf_mem_wr_t;

endpackage

// >>> logic/asf_store_formatter.sv
// accumulator store formatter: APB register file, decoder, shifter and store port
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_store_formatter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output asf_pkg::asf_mem_wr_t mem_wr
);

	// ====================================================================
	// state
	logic [`ASF_CTRL_W-1:0] ctrl;
	logic [15:0] shift_cnt [4];
	logic [39:0] acc [4];
	logic [15:0] store_count;
	logic illegal_seen;
	asf_pkg::asf_form_t last_form;

	// ====================================================================
	// APB decode; no wait state, the read mux output is registered during the setup phase
	wire setup_ph = psel & ~penable;
	wire access_done = psel & penable & pready;
	wire wr_en = access_done & pwrite;
	wire aligned = paddr[`ASF_ADDR_ALIGN] == 2'h0;
	wire hit_ctrl = paddr == `ASF_OFF_CTRL;
	wire hit_instr = paddr == `ASF_OFF_INSTR;
	wire hit_status = paddr == `ASF_OFF_STATUS;
	wire hit_result = paddr == `ASF_OFF_RESULT;
	wire hit_shift = aligned && ((paddr & `ASF_SHIFT_MASK) == `ASF_OFF_SHIFT_BASE);
	wire hit_acc = aligned && ((paddr & `ASF_ACC_MASK) == `ASF_OFF_ACC_BASE);
	wire mapped = hit_ctrl | hit_instr | hit_status | hit_result | hit_shift | hit_acc;
	wire [1:0] rd_sidx = paddr[`ASF_SHIFT_IDX];
	wire [1:0] rd_aidx = paddr[`ASF_ACC_IDX];
	wire [39:0] rd_acc = acc[rd_aidx];
	wire [31:0] status_word = {4'h0, last_form, illegal_seen, store_count};

	// read mux; the instruction port reads as zero
	wire [31:0] rd_word = hit_ctrl ? {28'h0000000, ctrl} :
		hit_status ? status_word :
		hit_result ? {mem_wr.data_hi, mem_wr.data_lo} :
		hit_shift ? {16'h0000, shift_cnt[rd_sidx]} :
		hit_acc ? (paddr[`ASF_ACC_HALF] ? {24'h000000, rd_acc[39:32]} : rd_acc[31:0]) :
		32'h00000000;

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata <= (setup_ph & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	// control word: mode bits steer the shifter, rounding and saturation paths
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 4'h0;
		end else if (wr_en && hit_ctrl) begin
			ctrl <= pwdata[`ASF_CTRL_W-1:0];
		end
	end

	// per-entry shift counts and accumulators
	for (genvar g = 0; g < 4; g++) begin : g_entry
		wire sel_shift = wr_en && hit_shift && (paddr[`ASF_SHIFT_IDX] == 2'(g));
		wire sel_acc = wr_en && hit_acc && (paddr[`ASF_ACC_IDX] == 2'(g));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				shift_cnt[g] <= 16'h0000;
			end else if (sel_shift) begin
				shift_cnt[g] <= pwdata[15:0];
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				acc[g] <= 40'h0000000000;
			end else if (sel_acc && paddr[`ASF_ACC_HALF]) begin
				acc[g][39:32] <= pwdata[7:0];
			end else if (sel_acc) begin
				acc[g][31:0] <= pwdata;
			end
		end
	end

	// ====================================================================
	// instruction decode from the word written to the instruction port
	wire exec = wr_en & hit_instr;
	wire lcm = ctrl[`ASF_CTRL_LCM];
	wire sxm = ctrl[`ASF_CTRL_SXM];
	wire store_saturation_enable = ctrl[`ASF_CTRL_SST];
	wire rounding_mode_select = ctrl[`ASF_CTRL_RDM];
	wire [7:0] op_byte = pwdata[`ASF_F_OPC];
	wire m_plain = pwdata[`ASF_F_OPC6] == `ASF_OP_HI_PLAIN;
	wire m_hi_rnd = op_byte == `ASF_OP_HI_RND;
	wire m_tx = op_byte == `ASF_OP_TX;
	wire m_tx_lo = m_tx && (pwdata[`ASF_F_SUB] == `ASF_SUB_TX_LO);
	wire m_tx_hi = m_tx && (pwdata[`ASF_F_SUB] == `ASF_SUB_TX_HI);
	wire m_imm_lo = op_byte == `ASF_OP_LO_IMM;
	wire m_imm_hi = op_byte == `ASF_OP_HI_IMM;
	wire m_long = op_byte == `ASF_OP_LONG;
	wire m_long_usat = op_byte == `ASF_OP_LONG_USAT;
	wire m_long_half = op_byte == `ASF_OP_LONG_HALF;
	wire m_dual = op_byte == `ASF_OP_DUAL;

	// one form per word; priority only guards against overlap
	wire asf_pkg::asf_form_t form = m_plain ? asf_pkg::ASF_FORM_HI_PLAIN :
		m_hi_rnd ? asf_pkg::ASF_FORM_HI_RND :
		m_tx_lo ? asf_pkg::ASF_FORM_TX_LO :
		m_tx_hi ? asf_pkg::ASF_FORM_TX_HI :
		m_imm_lo ? asf_pkg::ASF_FORM_IMM_LO :
		m_imm_hi ? asf_pkg::ASF_FORM_IMM_HI :
		m_long ? asf_pkg::ASF_FORM_LONG :
		m_long_usat ? asf_pkg::ASF_FORM_LONG_USAT :
		m_long_half ? asf_pkg::ASF_FORM_LONG_HALF :
		m_dual ? asf_pkg::ASF_FORM_DUAL :
		asf_pkg::ASF_FORM_NONE;
	wire legal = form != asf_pkg::ASF_FORM_NONE;
	wire [1:0] acc_sel = m_plain ? pwdata[`ASF_F_ACC2] : pwdata[`ASF_F_ACC3];
	wire [39:0] acc_val = acc[acc_sel];
	wire [15:0] acc_hi_word = acc_val[31:16];
	wire [15:0] acc_lo_word = acc_val[15:0];

	// ====================================================================
	// shift count selection
	wire [15:0] tx_val = shift_cnt[pwdata[`ASF_F_TXSEL]];
	wire [5:0] tx_low = tx_val[5:0];
	wire legacy_wrap = (tx_low >= `ASF_LEG_WRAP_LO) && (tx_low <= `ASF_LEG_WRAP_HI);
	wire [5:0] tx_legacy = legacy_wrap ? tx_low + `ASF_LEG_WRAP_ADD : tx_low;
	wire tx_big = ~tx_val[15] && (tx_val > `ASF_SHIFT_MAX16);
	wire tx_small = tx_val[15] && (tx_val < `ASF_SHIFT_MIN16);
	// large counts saturate instead of wrapping
	wire [5:0] tx_clamped = tx_big ? `ASF_SHIFT_MAX6 :
		tx_small ? `ASF_SHIFT_MIN6 : tx_low;
	wire [5:0] shift_amt = (m_tx_lo | m_tx_hi) ? (lcm ? tx_legacy : tx_clamped) :
		(m_imm_lo | m_imm_hi) ? pwdata[`ASF_F_IMM] :
		6'h00;

	// ====================================================================
	// keyword forcing in legacy mode when store saturation is on
	wire sat_form = m_hi_rnd | m_tx_lo | m_tx_hi | m_imm_lo | m_imm_hi;
	wire force_sat = lcm & store_saturation_enable & sat_form;
	wire force_rnd = force_sat & (m_hi_rnd | m_tx_hi);
	wire force_uns = force_sat & ~sxm;
	wire kw_rnd = pwdata[`ASF_F_RND] & (m_hi_rnd | m_tx_hi);
	wire do_rnd = kw_rnd | force_rnd;
	wire uns = force_uns | m_long_usat;
	wire sat_on = force_sat | m_long_usat;

	// ====================================================================
	// shifter: left up to 31, right up to 32, fill per extension mode
	wire [5:0] right_amt = 6'(~shift_amt + 6'h01);
	wire [39:0] shl = acc_val << shift_amt;
	wire [39:0] shr_arith = 40'($signed(acc_val) >>> right_amt);
	wire [39:0] shr_logic = acc_val >> right_amt;
	wire [39:0] shr = sxm ? shr_arith : shr_logic;
	wire [39:0] shifted = shift_amt[5] ? shr : shl;

	// rounding: add half an lsb of the upper word; mode 1 ties to even
	wire tie_even = rounding_mode_select && (shifted[15:0] == `ASF_HALF_LSB) && !shifted[16];
	wire [39:0] round_inc = (do_rnd && !tie_even) ? `ASF_ROUND_INC : 40'h0000000000;
	wire [39:0] rounded = shifted + round_inc;

	// overflow against the 40-bit shifted and rounded value
	wire in_sign = acc_val[39] & sxm;
	wire ovf_uns = rounded[39:32] != 8'h00;
	wire ovf_sgn = rounded[39:31] != {9{in_sign}};
	wire ovf = uns ? ovf_uns : ovf_sgn;
	wire sat_hit = sat_on & ovf & (lcm | m_long_usat);
	wire [39:0] sat_val = uns ? (rounded[39] ? `ASF_SAT_ZERO : `ASF_SAT_POS_U) :
		(in_sign ? `ASF_SAT_NEG_S : `ASF_SAT_POS_S);
	wire [39:0] final_val = sat_hit ? sat_val : rounded;

	// ====================================================================
	// store word selection; plain upper store skips the shifter entirely
	wire hi_single = m_hi_rnd | m_tx_hi | m_imm_hi;
	wire lo_single = m_tx_lo | m_imm_lo;
	wire [15:0] half_hi = {acc_val[31], acc_val[31:17]};
	wire [15:0] half_lo = {acc_val[15], acc_val[15:1]};
	wire [15:0] next_lo = m_plain ? acc_hi_word :
		hi_single ? final_val[31:16] :
		lo_single ? final_val[15:0] :
		m_long_usat ? final_val[15:0] :
		m_long_half ? half_lo :
		acc_lo_word;
	wire [15:0] next_hi = (m_long | m_dual) ? acc_hi_word :
		m_long_usat ? final_val[31:16] :
		m_long_half ? half_hi :
		16'h0000;
	wire asf_pkg::asf_kind_t next_kind = m_dual ? asf_pkg::ASF_KIND_DUAL :
		(m_long | m_long_usat | m_long_half) ? asf_pkg::ASF_KIND_LONG :
		asf_pkg::ASF_KIND_SINGLE;
	wire do_store = exec & legal;

	// store port: one pulse per legal instruction, data holds afterwards
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wr <= '0;
		end else begin
			mem_wr.valid <= do_store;
			if (do_store) begin
				mem_wr.kind <= next_kind;
				mem_wr.addr <= pwdata[`ASF_F_ADDR];
				mem_wr.data_hi <= next_hi;
				mem_wr.data_lo <= next_lo;
			end
		end
	end

	// bookkeeping; a new illegal word beats a clear in the same write
	wire clr_illegal = wr_en && hit_status && pwdata[16];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_count <= 16'h0000;
			illegal_seen <= 1'b0;
			last_form <= asf_pkg::ASF_FORM_NONE;
		end else begin
			if (do_store) store_count <= store_count + 16'h0001;
			if (exec && !legal) illegal_seen <= 1'b1;
			else if (clr_illegal) illegal_seen <= 1'b0;
			if (exec) last_form <= form;
		end
	end

	// ====================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_plain_hi_path: assert property (exec && m_plain |=>
		mem_wr.valid && mem_wr.data_lo == $past(acc_hi_word))
		else $error("plain upper store data wrong");
	a_plain_decode: assert property (exec && pwdata[31:26] == 6'h2F |=>
		mem_wr.valid && mem_wr.kind == asf_pkg::ASF_KIND_SINGLE)
		else $error("plain upper store not decoded");
	a_no_round_hi: assert property (exec && m_hi_rnd && !pwdata[8] && !force_sat |=>
		mem_wr.data_lo == $past(acc_hi_word))
		else $error("rounded upper store rounded without keyword");
	a_uns_sat_max: assert property (exec && m_hi_rnd && lcm && store_saturation_enable && !sxm
		&& !acc_val[39] && acc_val[38:32] != 7'h00 |=> mem_wr.data_lo == 16'hFFFF)
		else $error("forced unsigned saturation missing");
	a_sgn_sat_max: assert property (exec && m_hi_rnd && lcm && store_saturation_enable && sxm
		&& !acc_val[39] && acc_val[38:31] != 8'h00 |=> mem_wr.data_lo == 16'h7FFF)
		else $error("forced signed saturation missing");
	a_count_clamp: assert property (exec && (m_tx_lo | m_tx_hi) && !lcm && !tx_val[15]
		&& tx_val[14:5] != 10'h000 |-> shift_amt == 6'h1F)
		else $error("shift count not clamped");
	a_legacy_wrap: assert property (exec && (m_tx_lo | m_tx_hi) && lcm
		&& tx_val[5:4] == 2'h2
		|-> shift_amt == {2'h3, tx_val[3:0]})
		else $error("legacy count not wrapped");
	a_half_long: assert property (exec && m_long_half |=>
		mem_wr.data_hi[15] == mem_wr.data_hi[14] && mem_wr.kind == asf_pkg::ASF_KIND_LONG)
		else $error("halved long store wrong");
	a_usat_neg: assert property (exec && m_long_usat && acc_val[39] |=>
		mem_wr.data_hi == 16'h0000 && mem_wr.data_lo == 16'h0000)
		else $error("unsigned long saturation wrong");
	a_one_cycle: assert property (do_store |=> mem_wr.valid ##1 !mem_wr.valid)
		else $error("store pulse not one cycle");

	c_plain: cover property (exec && m_plain);
	c_legacy_wrap: cover property (exec && m_tx && lcm && legacy_wrap);
	c_usat_hit: cover property (exec && m_long_usat && sat_hit);
	c_dual: cover property (exec && m_dual);

endmodule

// >>> dv/asf_mem_model.sv
// data-memory write port model: takes every store the formatter issues
`timescale 1ns/1ps
module asf_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input asf_pkg::asf_mem_wr_t mem_wr,
	output asf_pkg::asf_mem_wr_t last,
	output int count
);
	// ====================================================================
	// capture
	// the port has no back-pressure, so each pulse is taken at once;
	// a pulse that stands two cycles shows up as two stores
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= '0;
			count <= 0;
		end else if (mem_wr.valid) begin
			last <= mem_wr;
			count <= count + 1;
		end
	end
endmodule

// >>> dv/tb.sv
// self-checking bench for the accumulator store formatter
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	asf_pkg::asf_mem_wr_t mem_wr;
	asf_pkg::asf_mem_wr_t last;
	int count;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int c0;

	asf_store_formatter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_wr(mem_wr));
	asf_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_wr(mem_wr), .last(last),
		.count(count));

	// ====================================================================
	// clock and hang guard
	always #5 pclk = ~pclk;
	// whole run is well under a thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ====================================================================
	// helpers
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; pready and read data are taken at the rising edge
	// that completes the access, the request is released only after it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) cmp("pready", 32'h00000001, 32'h00000000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
		input logic ee);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h00000000, r, e);
		cmp("read data", exp, r & m);
		cmp("pslverr", {31'h0, ee}, {31'h0, e});
	endtask

	// low word at 0x20+8i, top byte at 0x24+8i
	task automatic set_acc(input int i, input logic [39:0] v);
		wr(8'h20 + 8'(i * 8), v[31:0]);
		wr(8'h24 + 8'(i * 8), {24'h000000, v[39:32]});
	endtask

	task automatic store(input logic [31:0] ins, input logic [1:0] k, input logic [15:0] hi,
		input logic [15:0] lo);
		int n0;
		n0 = count;
		wr(8'h04, ins);
		repeat (3) @(negedge pclk);
		cmp("store pulses", 32'(n0 + 1), 32'(count));
		cmp("kind", {30'h0, k}, {30'h0, last.kind});
		cmp("addr", {24'h0, ins[23:16]}, {24'h0, last.addr});
		cmp("data", {hi, lo}, {last.data_hi, last.data_lo});
	endtask

	// ====================================================================
	// tests; ctrl bits: 0 legacy, 1 sign ext, 2 store sat, 3 round mode
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(8'h00, 32'hFFFFFFFF, 32'h00000000, 1'b0);
		rd_chk(8'h08, 32'hFFFFFFFF, 32'h00020000, 1'b0);
		rd_chk(8'h40, 32'hFFFFFFFF, 32'h00000000, 1'b1);
		// plain upper store must not see forced saturation
		wr(8'h00, 32'h00000005);
		set_acc(0, 40'h123456789A);
		store(32'hBC550000, 2'h0, 16'h0000, 16'h3456);
		// rounding only on request, two rounding modes
		wr(8'h00, 32'h00000000);
		set_acc(1, 40'h0012348000);
		store(32'hE8104100, 2'h0, 16'h0000, 16'h1235);
		store(32'hE8114000, 2'h0, 16'h0000, 16'h1234);
		wr(8'h00, 32'h00000008);
		store(32'hE8124100, 2'h0, 16'h0000, 16'h1234);
		// legacy forced keywords on rounded upper store
		set_acc(1, 40'h0080008000);
		wr(8'h00, 32'h00000005);
		store(32'hE8134000, 2'h0, 16'h0000, 16'h8001);
		wr(8'h00, 32'h00000007);
		store(32'hE8144000, 2'h0, 16'h0000, 16'h7FFF);
		set_acc(1, 40'hFF00000000);
		store(32'hE8154000, 2'h0, 16'h0000, 16'h8000);
		set_acc(1, 40'h0100000000);
		wr(8'h00, 32'h00000005);
		store(32'hE8164000, 2'h0, 16'h0000, 16'hFFFF);
		// register shift, clamp and extension
		wr(8'h00, 32'h00000002);
		set_acc(2, 40'hFF80000000);
		wr(8'h10, 32'h0000FF00);
		store(32'hE7208000, 2'h0, 16'h0000, 16'hFFFF);
		wr(8'h00, 32'h00000000);
		store(32'hE7218000, 2'h0, 16'h0000, 16'h00FF);
		set_acc(2, 40'h0000000001);
		wr(8'h14, 32'h00000040);
		store(32'hE7229800, 2'h0, 16'h0000, 16'h8000);
		set_acc(2, 40'h0000001280);
		wr(8'h18, 32'h00000008);
		store(32'hE723A800, 2'h0, 16'h0000, 16'h0012);
		store(32'hE724A900, 2'h0, 16'h0000, 16'h0013);
		// legacy count decoding
		wr(8'h00, 32'h00000001);
		set_acc(3, 40'h0000001234);
		wr(8'h1C, 32'h00000044);
		store(32'hE730F000, 2'h0, 16'h0000, 16'h2340);
		wr(8'h1C, 32'h00000028);
		store(32'hE731F000, 2'h0, 16'h0000, 16'h0012);
		// legacy forced saturation on lower store
		wr(8'h1C, 32'h00000000);
		wr(8'h00, 32'h00000005);
		set_acc(3, 40'h0100001234);
		store(32'hE732F000, 2'h0, 16'h0000, 16'hFFFF);
		wr(8'h00, 32'h00000007);
		set_acc(3, 40'hFF00001234);
		store(32'hE733F000, 2'h0, 16'h0000, 16'h0000);
		// immediate shifts, both signs
		wr(8'h00, 32'h00000000);
		set_acc(3, 40'h0000001234);
		store(32'hE934C400, 2'h0, 16'h0000, 16'h2340);
		store(32'hE935FC00, 2'h0, 16'h0000, 16'h0123);
		store(32'hEA36D000, 2'h0, 16'h0000, 16'h1234);
		// long, unsigned saturated long, dual and halved long
		store(32'hEB400000, 2'h1, 16'h3456, 16'h789A);
		store(32'hEC410000, 2'h1, 16'hFFFF, 16'hFFFF);
		store(32'hEE420000, 2'h2, 16'h3456, 16'h789A);
		set_acc(0, 40'h0012345678);
		store(32'hEC430000, 2'h1, 16'h1234, 16'h5678);
		wr(8'h00, 32'h00000002);
		set_acc(0, 40'h0086428642);
		store(32'hED440000, 2'h1, 16'hC321, 16'hC321);
		// control word left alone, illegal word refused
		rd_chk(8'h00, 32'hFFFFFFFF, 32'h00000002, 1'b0);
		c0 = count;
		wr(8'h04, 32'h00000000);
		repeat (3) @(negedge pclk);
		cmp("store pulses", 32'(c0), 32'(count));
		rd_chk(8'h08, 32'h0001FFFF, {15'h0000, 1'b1, 16'(count)}, 1'b0);
		rd_chk(8'h04, 32'hFFFFFFFF, 32'h00000000, 1'b0);
		tally_and_finish();
	end
endmodule
